// *** src/fpctx_coproc.sv ***
`timescale 1ns/10ps
`default_nettype none
module fpctx_coproc (
	input  wire logic                         clk,
	input  wire logic                         srst,
	input  wire logic                         cmd_valid,
	input  wire fpctx_pkg::fpctx_cmd_t        cmd_kind,
	input  wire fpctx_pkg::fpctx_fmt_t        cmd_fmt,
	input  wire logic                         wr_valid,
	input  wire logic [fpctx_pkg::WORD_W-1:0] wr_data,
	input  wire logic                         rd_ready,
	output fpctx_pkg::fpctx_resp_t            resp_r,
	output logic                              rd_valid_r,
	output logic [fpctx_pkg::WORD_W-1:0]      rd_data_r,
	output logic [fpctx_pkg::EXT_W-1:0]       result_r,
	output logic                              result_valid_r,
	output logic                              busy_r
);
	import fpctx_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fpctx_st_t                  st_r, st_nxt;
	fpctx_fmt_t                 fmt_r, fmt_nxt;
	logic [1:0]                 got_r, got_nxt;
	logic [2:0][WORD_W-1:0]     op_r, op_nxt;
	logic [CNT_W-1:0]           calc_r, calc_nxt;
	logic [CNT_W-1:0]           idx_r, idx_nxt;
	logic [CNT_W-1:0]           len_r, len_nxt;
	logic                       pend_r, pend_nxt;
	logic                       ok_r, ok_nxt;
	logic                       start_r, start_nxt;
	logic [2:0]                 ph_r, ph_nxt;
	logic [EXT_W-1:0]           ecu_r, ecu_nxt;
	logic [EXT_W-1:0]           res_nxt;
	logic                       resv_nxt;
	fpctx_resp_t                resp_nxt;
	logic                       rdv_nxt;
	logic [WORD_W-1:0]          rdd_nxt;
	logic                       busy_nxt;
	logic                       halted, save_go;
	logic [CNT_W-1:0]           save_len, sidx;
	logic [WORD_W-1:0]          slot_data, ph_word;

	fpctx_conv_if cv ();

	assign cv.start = start_r;
	assign cv.fmt = fmt_r;
	assign cv.w0 = op_r[0];
	assign cv.w1 = op_r[1];
	assign cv.w2 = op_r[2];

	fpctx_conv u_conv (
		.clk  (clk),
		.srst (srst),
		.cv   (cv)
	);

	// ----------------------------------------------------------------
	// frame word source
	// ----------------------------------------------------------------
	always_comb begin
		ph_word = '0;
		ph_word[PH_FMT_LSB +: 3] = fmt_r;
		ph_word[PH_GOT_LSB +: 2] = got_r;
		ph_word[PH_HOLD_BIT] = ph_r[0];
		ph_word[PH_COLL_BIT] = ph_r[1];
		ph_word[PH_RESV_BIT] = ph_r[2];
		sidx = idx_r + 8'h01;
		case (sidx)
		SLOT_PHASE:         slot_data = ph_word;
		SLOT_OP:            slot_data = op_r[0];
		SLOT_OP + 8'h01:    slot_data = op_r[1];
		SLOT_OP + 8'h02:    slot_data = op_r[2];
		SLOT_CALC:          slot_data = {24'h000000, calc_r};
		SLOT_RES:           slot_data = fpctx_ext_word(result_r, 2'h0);
		SLOT_RES + 8'h01:   slot_data = fpctx_ext_word(result_r, 2'h1);
		SLOT_RES + 8'h02:   slot_data = fpctx_ext_word(result_r, 2'h2);
		SLOT_ECU:           slot_data = fpctx_ext_word(ecu_r, 2'h0);
		SLOT_ECU + 8'h01:   slot_data = fpctx_ext_word(ecu_r, 2'h1);
		SLOT_ECU + 8'h02:   slot_data = fpctx_ext_word(ecu_r, 2'h2);
		default:            slot_data = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		fmt_nxt = fmt_r;
		got_nxt = got_r;
		op_nxt = op_r;
		calc_nxt = calc_r;
		idx_nxt = idx_r;
		len_nxt = len_r;
		pend_nxt = pend_r;
		ok_nxt = ok_r | cv.done;
		start_nxt = 1'b0;
		ph_nxt = ph_r;
		ecu_nxt = ecu_r;
		res_nxt = result_r;
		resv_nxt = result_valid_r;
		resp_nxt = resp_r;
		rdv_nxt = rd_valid_r;
		rdd_nxt = rd_data_r;
		save_go = 1'b0;
		save_len = len_r;
		// the execution side freezes while a frame moves
		halted = (st_r == ST_SAVE) || (st_r == ST_RESTORE);
		if (!halted && calc_r != '0) begin
			calc_nxt = calc_r - 8'h01;
			if (calc_r == 8'h01) begin
				res_nxt = ecu_r;
				resv_nxt = 1'b1;
				resp_nxt = RESP_DONE;
			end
		end
		// operand passes to execution only once the previous one is done
		if (st_r == ST_HOLD && ok_r && calc_r == '0) begin
			ecu_nxt = cv.ext;
			calc_nxt = CALC_CYCLES;
			resv_nxt = 1'b0;
			st_nxt = ST_IDLE;
		end
		if (st_r == ST_COLLECT && wr_valid) begin
			op_nxt[got_r] = wr_data;
			got_nxt = got_r + 2'h1;
			if (got_r + 2'h1 == fpctx_need(fmt_r)) begin
				st_nxt = ST_HOLD;
				start_nxt = 1'b1;
				ok_nxt = 1'b0;
				resp_nxt = RESP_NONE;
			end
		end
		if (pend_r && st_r == ST_IDLE && calc_r == '0) begin
			save_go = 1'b1;
			save_len = IDLE_WORDS;
		end
		if (cmd_valid && !pend_r) begin
			case (cmd_kind)
			CMD_INSTR: begin
				if (st_r == ST_NULL || st_r == ST_IDLE) begin
					st_nxt = ST_COLLECT;
					fmt_nxt = cmd_fmt;
					got_nxt = 2'h0;
					resp_nxt = RESP_FETCH;
				end else begin
					resp_nxt = RESP_WAIT;
				end
			end
			CMD_SAVE: begin
				case (st_r)
				ST_NULL: begin
					save_go = 1'b1;
					save_len = NULL_WORDS;
				end
				ST_IDLE: begin
					if (calc_r == '0) begin
						save_go = 1'b1;
						save_len = IDLE_WORDS;
					end else if (calc_r < BUSY_WORDS) begin
						pend_nxt = 1'b1;
						resp_nxt = RESP_WAIT;
					end else begin
						save_go = 1'b1;
						save_len = BUSY_WORDS;
					end
				end
				ST_COLLECT, ST_HOLD: begin
					save_go = 1'b1;
					save_len = BUSY_WORDS;
				end
				default: resp_nxt = RESP_WAIT;
				endcase
			end
			CMD_RESTORE: begin
				if (!halted) begin
					st_nxt = ST_RESTORE;
					idx_nxt = '0;
					resp_nxt = RESP_RESTORE;
				end else begin
					resp_nxt = RESP_WAIT;
				end
			end
			default: resp_nxt = resp_r;
			endcase
		end else if (cmd_valid) begin
			resp_nxt = RESP_WAIT;
		end
		if (save_go) begin
			ph_nxt = {resv_nxt, st_nxt == ST_COLLECT, st_nxt == ST_HOLD};
			st_nxt = ST_SAVE;
			len_nxt = save_len;
			idx_nxt = '0;
			pend_nxt = 1'b0;
			rdv_nxt = 1'b1;
			resp_nxt = RESP_SAVE;
			rdd_nxt = '0;
			if (save_len != NULL_WORDS) begin
				rdd_nxt[FW_VER_LSB +: 8] = FRAME_VERSION;
				rdd_nxt[FW_SIZE_LSB +: 8] =
					(save_len == IDLE_WORDS) ? IDLE_SIZE : BUSY_SIZE;
			end
		end
		if (st_r == ST_SAVE && rd_valid_r && rd_ready) begin
			idx_nxt = sidx;
			rdd_nxt = slot_data;
			if (sidx == len_r) begin
				rdv_nxt = 1'b0;
				resp_nxt = RESP_NONE;
				rdd_nxt = '0;
				st_nxt = (len_r == NULL_WORDS) ? ST_NULL : ST_IDLE;
				// the suspended work now lives in the saved frame
				if (len_r == BUSY_WORDS) begin
					calc_nxt = '0;
					got_nxt = 2'h0;
				end
			end
		end
		if (st_r == ST_RESTORE && wr_valid) begin
			idx_nxt = sidx;
			if (idx_r == '0) begin
				if (wr_data[FW_VER_LSB +: 8] == NULL_VERSION) begin
					// same values as the synchronous reset
					st_nxt = ST_NULL;
					fmt_nxt = FMT_BYTE;
					got_nxt = '0;
					op_nxt = '0;
					calc_nxt = '0;
					ph_nxt = '0;
					ecu_nxt = '0;
					res_nxt = '0;
					resv_nxt = 1'b0;
					ok_nxt = 1'b0;
					resp_nxt = RESP_NONE;
				end else if (wr_data[FW_VER_LSB +: 8] == FRAME_VERSION &&
					wr_data[FW_SIZE_LSB +: 8] == IDLE_SIZE) begin
					len_nxt = IDLE_WORDS;
				end else if (wr_data[FW_VER_LSB +: 8] == FRAME_VERSION &&
					wr_data[FW_SIZE_LSB +: 8] == BUSY_SIZE) begin
					len_nxt = BUSY_WORDS;
				end else begin
					st_nxt = ST_IDLE;
					resp_nxt = RESP_FRAME_ERR;
				end
			end else begin
				case (idx_r)
				SLOT_PHASE: begin
					fmt_nxt = fpctx_fmt_t'(wr_data[PH_FMT_LSB +: 3]);
					got_nxt = wr_data[PH_GOT_LSB +: 2];
					ph_nxt = {wr_data[PH_RESV_BIT], wr_data[PH_COLL_BIT],
						wr_data[PH_HOLD_BIT]};
				end
				SLOT_OP:          op_nxt[0] = wr_data;
				SLOT_OP + 8'h01:  op_nxt[1] = wr_data;
				SLOT_OP + 8'h02:  op_nxt[2] = wr_data;
				SLOT_CALC:        calc_nxt = wr_data[CNT_W-1:0];
				SLOT_RES:         res_nxt[EXT_W-1 -: XHI_W] =
					wr_data[WORD_W-1 -: XHI_W];
				SLOT_RES + 8'h01: res_nxt[2*WORD_W-1 -: WORD_W] = wr_data;
				SLOT_RES + 8'h02: res_nxt[WORD_W-1:0] = wr_data;
				SLOT_ECU:         ecu_nxt[EXT_W-1 -: XHI_W] =
					wr_data[WORD_W-1 -: XHI_W];
				SLOT_ECU + 8'h01: ecu_nxt[2*WORD_W-1 -: WORD_W] = wr_data;
				SLOT_ECU + 8'h02: ecu_nxt[WORD_W-1:0] = wr_data;
				default:          ecu_nxt = ecu_r;
				endcase
				if (sidx == len_r) begin
					resv_nxt = ph_r[2];
					resp_nxt = RESP_NONE;
					st_nxt = ST_IDLE;
					if (ph_r[1]) begin
						st_nxt = ST_COLLECT;
						resp_nxt = RESP_FETCH;
					end else if (ph_r[0]) begin
						// operand is rebuilt from the restored words
						st_nxt = ST_HOLD;
						start_nxt = 1'b1;
						ok_nxt = 1'b0;
					end
				end
			end
		end
		busy_nxt = (calc_nxt != '0) || (st_nxt == ST_COLLECT) ||
			(st_nxt == ST_HOLD);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= ST_NULL;
			fmt_r <= FMT_BYTE;
			got_r <= '0;
			op_r <= '0;
			calc_r <= '0;
			idx_r <= '0;
			len_r <= '0;
			pend_r <= 1'b0;
			ok_r <= 1'b0;
			start_r <= 1'b0;
			ph_r <= '0;
			ecu_r <= '0;
			result_r <= '0;
			result_valid_r <= 1'b0;
			resp_r <= RESP_NONE;
			rd_valid_r <= 1'b0;
			rd_data_r <= '0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			fmt_r <= fmt_nxt;
			got_r <= got_nxt;
			op_r <= op_nxt;
			calc_r <= calc_nxt;
			idx_r <= idx_nxt;
			len_r <= len_nxt;
			pend_r <= pend_nxt;
			ok_r <= ok_nxt;
			start_r <= start_nxt;
			ph_r <= ph_nxt;
			ecu_r <= ecu_nxt;
			result_r <= res_nxt;
			result_valid_r <= resv_nxt;
			resp_r <= resp_nxt;
			rd_valid_r <= rdv_nxt;
			rd_data_r <= rdd_nxt;
			busy_r <= busy_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	null_save_a:
	assert property (cmd_valid && cmd_kind == CMD_SAVE && st_r == ST_NULL
		&& !pend_r |=> rd_valid_r && rd_data_r == '0 && len_r == 8'h01)
	else $error("empty save is not one zero word");

	idle_save_a:
	assert property (cmd_valid && cmd_kind == CMD_SAVE && st_r == ST_IDLE
		&& calc_r == '0 && !pend_r |=> len_r == IDLE_WORDS && rd_valid_r)
	else $error("idle save has wrong length");

	busy_save_a:
	assert property (cmd_valid && cmd_kind == CMD_SAVE && !pend_r &&
		(st_r == ST_COLLECT || st_r == ST_HOLD) |=> len_r == BUSY_WORDS)
	else $error("busy save has wrong length");

	defer_save_a:
	assert property (cmd_valid && cmd_kind == CMD_SAVE && st_r == ST_IDLE
		&& !pend_r && calc_r != '0 && calc_r < BUSY_WORDS |=>
		pend_r && st_r == ST_IDLE ##[1:60] st_r == ST_SAVE
		&& len_r == IDLE_WORDS)
	else $error("short work not finished before idle save");

	frame_size_a:
	assert property (st_r == ST_SAVE && rd_valid_r && idx_r == '0 &&
		len_r != 8'h01 |-> rd_data_r[23:16] ==
		((len_r == IDLE_WORDS) ? 8'h38 : 8'hd0))
	else $error("format word size field wrong");

	halt_save_a:
	assert property (st_r == ST_SAVE && $past(st_r) == ST_SAVE |->
		$stable(calc_r) && $stable(ecu_r))
	else $error("execution moved during save");

	null_rest_a:
	assert property (st_r == ST_RESTORE && wr_valid && idx_r == '0 &&
		wr_data[31:24] == 8'h00 |=> st_r == ST_NULL && calc_r == '0 &&
		!result_valid_r && !busy_r)
	else $error("empty restore did not reset");

	wait_resp_a:
	assert property (cmd_valid && cmd_kind == CMD_INSTR &&
		(st_r == ST_COLLECT || st_r == ST_HOLD) |=> resp_r == RESP_WAIT)
	else $error("new instruction not told to wait");

	fetch_resp_a:
	assert property (cmd_valid && cmd_kind == CMD_INSTR && !pend_r &&
		st_r == ST_IDLE |=> resp_r == RESP_FETCH && st_r == ST_COLLECT)
	else $error("operand fetch not requested");

	calc_end_a:
	assert property (calc_r == 8'h01 && !halted |=>
		result_valid_r && result_r == $past(ecu_r) &&
		(resp_r == RESP_DONE || $past(cmd_valid || wr_valid)))
	else $error("result not delivered at end of work");
endmodule
`default_nettype wire

// *** src/fpctx_pkg.sv ***
`default_nettype none
package fpctx_pkg;
	// ----------------------------------------------------------------
	// widths and extended layout
	// ----------------------------------------------------------------
	localparam int WORD_W      = 32;
	localparam int EXT_W       = 80;
	localparam int CNT_W       = 8;
	localparam int INT_TOP     = 31;
	localparam int SGL_EXP_W   = 8;
	localparam int SGL_FRAC_W  = 23;
	localparam int DBL_EXP_W   = 11;
	localparam int DBL_FRAC_W  = 52;
	localparam int XHI_W       = 16;
	localparam logic [14:0] EXT_BIAS    = 15'h3fff;
	localparam logic [14:0] EXT_EXP_MAX = 15'h7fff;
	localparam logic [14:0] SGL_BIAS    = 15'h007f;
	localparam logic [14:0] DBL_BIAS    = 15'h03ff;
	localparam logic [14:0] INT_EXP     = EXT_BIAS + 15'h001f;
	// ----------------------------------------------------------------
	// save frames
	// ----------------------------------------------------------------
	localparam int WORD_BYTES        = 4;
	localparam int FRAME_EXTRA_BYTES = 32;
	localparam int BASE_IDLE_BYTES   = 24;
	localparam int BASE_BUSY_BYTES   = 176;
	localparam int IDLE_BYTES = BASE_IDLE_BYTES + FRAME_EXTRA_BYTES;
	localparam int BUSY_BYTES = BASE_BUSY_BYTES + FRAME_EXTRA_BYTES;
	localparam logic [7:0] IDLE_SIZE = 8'(IDLE_BYTES);
	localparam logic [7:0] BUSY_SIZE = 8'(BUSY_BYTES);
	localparam logic [CNT_W-1:0] NULL_WORDS = 8'h01;
	localparam logic [CNT_W-1:0] IDLE_WORDS =
		CNT_W'(IDLE_BYTES / WORD_BYTES + 1);
	localparam logic [CNT_W-1:0] BUSY_WORDS =
		CNT_W'(BUSY_BYTES / WORD_BYTES + 1);
	localparam logic [7:0] NULL_VERSION  = 8'h00;
	localparam logic [7:0] FRAME_VERSION = 8'h4c; // arbitrary value
	localparam int FW_VER_LSB  = 24;
	localparam int FW_SIZE_LSB = 16;
	localparam logic [CNT_W-1:0] SLOT_PHASE = 8'h01;
	localparam logic [CNT_W-1:0] SLOT_OP    = 8'h02;
	localparam logic [CNT_W-1:0] SLOT_CALC  = 8'h05;
	localparam logic [CNT_W-1:0] SLOT_RES   = 8'h06;
	localparam logic [CNT_W-1:0] SLOT_ECU   = 8'h09;
	localparam int PH_FMT_LSB  = 0;
	localparam int PH_GOT_LSB  = 4;
	localparam int PH_HOLD_BIT = 8;
	localparam int PH_COLL_BIT = 9;
	localparam int PH_RESV_BIT = 10;
	localparam logic [CNT_W-1:0] CALC_CYCLES = 8'h28;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {FMT_BYTE, FMT_WORD, FMT_LONG, FMT_SGL,
		FMT_DBL, FMT_EXT, FMT_PACKED} fpctx_fmt_t;
	typedef enum logic [1:0] {CMD_INSTR, CMD_SAVE, CMD_RESTORE} fpctx_cmd_t;
	typedef enum logic [2:0] {RESP_NONE, RESP_WAIT, RESP_FETCH, RESP_DONE,
		RESP_SAVE, RESP_RESTORE, RESP_FRAME_ERR} fpctx_resp_t;
	typedef enum logic [2:0] {ST_NULL, ST_IDLE, ST_COLLECT, ST_HOLD,
		ST_SAVE, ST_RESTORE} fpctx_st_t;

	function automatic logic [1:0] fpctx_need(input fpctx_fmt_t f);
		case (f)
		FMT_DBL:             return 2'h2;
		FMT_EXT, FMT_PACKED: return 2'h3;
		default:             return 2'h1;
		endcase
	endfunction

	// extended value as three long words, bottom 16 bits of word 0 unused
	function automatic logic [WORD_W-1:0] fpctx_ext_word(
		input logic [EXT_W-1:0] x, input logic [1:0] k);
		case (k)
		2'h0:    return {x[EXT_W-1 -: XHI_W], 16'h0000};
		2'h1:    return x[2*WORD_W-1 -: WORD_W];
		default: return x[WORD_W-1:0];
		endcase
	endfunction
endpackage
`default_nettype wire

// *** src/fpctx_conv_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface fpctx_conv_if;
	import fpctx_pkg::*;
	logic              start;
	fpctx_fmt_t        fmt;
	logic [WORD_W-1:0] w0;
	logic [WORD_W-1:0] w1;
	logic [WORD_W-1:0] w2;
	logic              done;
	logic [EXT_W-1:0]  ext;
	modport ctl (output start, fmt, w0, w1, w2, input done, ext);
	modport cvt (input start, fmt, w0, w1, w2, output done, ext);
endinterface
`default_nettype wire

// *** src/fpctx_conv.sv ***
`timescale 1ns/10ps
`default_nettype none
module fpctx_conv (
	input  wire logic       clk,
	input  wire logic       srst,
	fpctx_conv_if.cvt       cv
);
	import fpctx_pkg::*;
	logic [EXT_W-1:0]      ext_r, ext_nxt;
	logic                  done_r, done_nxt;
	logic [WORD_W-1:0]     ival, mag;
	logic [4:0]            lz;
	logic                  found, isgn;
	logic [SGL_EXP_W-1:0]  sexp;
	logic [SGL_FRAC_W-1:0] sfrac;
	logic [DBL_EXP_W-1:0]  dexp;
	logic [DBL_FRAC_W-1:0] dfrac;

	always_comb begin
		ival = '0;
		lz = '0;
		found = 1'b0;
		ext_nxt = ext_r;
		done_nxt = cv.start;
		sexp = cv.w0[SGL_FRAC_W +: SGL_EXP_W];
		sfrac = cv.w0[SGL_FRAC_W-1:0];
		dexp = cv.w0[DBL_FRAC_W-WORD_W +: DBL_EXP_W];
		dfrac = {cv.w0[DBL_FRAC_W-WORD_W-1:0], cv.w1};
		case (cv.fmt)
		FMT_BYTE: ival = {{24{cv.w0[7]}}, cv.w0[7:0]};
		FMT_WORD: ival = {{16{cv.w0[15]}}, cv.w0[15:0]};
		FMT_LONG: ival = cv.w0;
		default:  ival = '0;
		endcase
		isgn = ival[INT_TOP];
		mag = isgn ? (~ival + 32'h0000_0001) : ival;
		for (int i = INT_TOP; i >= 0; i--) begin
			if (!found && mag[i]) begin
				lz = 5'(INT_TOP - i);
				found = 1'b1;
			end
		end
		if (cv.start) begin
			case (cv.fmt)
			FMT_BYTE, FMT_WORD, FMT_LONG: begin
				if (mag == '0)
					ext_nxt = '0;
				else
					ext_nxt = {isgn, INT_EXP - {10'h000, lz}, mag << lz,
						32'h0000_0000};
			end
			FMT_SGL: begin
				if (sexp == '0 && sfrac == '0)
					ext_nxt = {cv.w0[WORD_W-1], 79'h0};
				else if (&sexp)
					ext_nxt = {cv.w0[WORD_W-1], EXT_EXP_MAX, 1'b0, sfrac, 40'h0};
				else if (sexp == '0)
					ext_nxt = {cv.w0[WORD_W-1], EXT_BIAS - SGL_BIAS + 15'h0001,
						1'b0, sfrac, 40'h0};
				else
					ext_nxt = {cv.w0[WORD_W-1], {7'h00, sexp} + EXT_BIAS - SGL_BIAS,
						1'b1, sfrac, 40'h0};
			end
			FMT_DBL: begin
				if (dexp == '0 && dfrac == '0)
					ext_nxt = {cv.w0[WORD_W-1], 79'h0};
				else if (&dexp)
					ext_nxt = {cv.w0[WORD_W-1], EXT_EXP_MAX, 1'b0, dfrac, 11'h0};
				else if (dexp == '0)
					ext_nxt = {cv.w0[WORD_W-1], EXT_BIAS - DBL_BIAS + 15'h0001,
						1'b0, dfrac, 11'h0};
				else
					ext_nxt = {cv.w0[WORD_W-1], {4'h0, dexp} + EXT_BIAS - DBL_BIAS,
						1'b1, dfrac, 11'h0};
			end
			FMT_EXT: begin
				ext_nxt = {cv.w0[WORD_W-1 -: XHI_W], cv.w1, cv.w2};
			end
			// decimal strings are not converted and give zero
			default: ext_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_r <= '0;
			done_r <= 1'b0;
		end else begin
			ext_r <= ext_nxt;
			done_r <= done_nxt;
		end
	end

	assign cv.ext = ext_r;
	assign cv.done = done_r;

	sgl_bias_a:
	assert property (@(posedge clk) disable iff (srst)
		cv.start && cv.fmt == FMT_SGL && sexp != '0 && !(&sexp) |=>
		cv.done && cv.ext[78:64] == {7'h00, $past(sexp)} + 15'h3f80)
	else $error("single exponent not rebiased");

	int_norm_a:
	assert property (@(posedge clk) disable iff (srst)
		cv.start && cv.fmt == FMT_LONG && mag != '0 |=>
		cv.ext[63] && cv.ext[79] == $past(isgn))
	else $error("integer not normalized");
endmodule
`default_nettype wire

// *** sim/fpctx_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module fpctx_host (
	input  wire logic                 clk,
	output var logic                  cmd_valid,
	output var fpctx_pkg::fpctx_cmd_t cmd_kind,
	output var fpctx_pkg::fpctx_fmt_t cmd_fmt,
	output var logic                  wr_valid,
	output var logic [31:0]           wr_data,
	output var logic                  rd_ready
);
	import fpctx_pkg::*;
	// upper address lines carry the unit id; with the cpu-space code
	// the decode picks one of eight units
	localparam logic [2:0] UNIT_ID = 3'h5; // arbitrary value
	logic [7:0]            unit_sel;
	assign unit_sel = 8'h01 << UNIT_ID;
	// ------------------------------------------------------------
	// host side: every transfer is made here, never by the unit
	// ------------------------------------------------------------
	initial begin
		cmd_valid = 1'b0;
		cmd_kind  = CMD_INSTR;
		cmd_fmt   = FMT_BYTE;
		wr_valid  = 1'b0;
		wr_data   = 32'h0;
		rd_ready  = 1'b0;
	end
	// random stalls on the save stream
	always @(posedge clk) rd_ready <= 1'($urandom % 2);
	// save is taken mid-instruction while operands are fetched or held, but waits for running work to end only if fewer than BUSY_WORDS cycles remain
	// command first, response read afterwards
	task automatic cmd(input fpctx_cmd_t k, input fpctx_fmt_t f);
		@(posedge clk);
		cmd_valid <= unit_sel[UNIT_ID];
		cmd_kind  <= k;
		cmd_fmt   <= f;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_kind  <= fpctx_cmd_t'(~k);
		cmd_fmt   <= fpctx_fmt_t'(~f);
		@(posedge clk);
		#1;
	endtask
	// released data shows the inverse, not a stale copy
	task automatic wr(input logic [31:0] d);
		@(posedge clk);
		wr_valid <= 1'b1;
		wr_data  <= d;
		@(posedge clk);
		wr_valid <= 1'b0;
		wr_data  <= ~d;
	endtask
endmodule
`default_nettype wire

// *** sim/fpctx_coproc_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module fpctx_coproc_tb;
	import fpctx_pkg::*;
	logic        clk, srst, cmd_valid, wr_valid, rd_ready, rv_q;
	logic        rd_valid_r, result_valid_r, busy_r;
	fpctx_cmd_t  cmd_kind;
	fpctx_fmt_t  cmd_fmt;
	fpctx_resp_t resp_r;
	logic [31:0] wr_data, rd_data_r, v, fr[0:63], w[0:2], fw_q[$];
	logic [79:0] result_r, x, xq[$];
	int          n_q[$], fn, nd, err_count, comparisons;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	fpctx_coproc i_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_fmt(cmd_fmt), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_ready(rd_ready), .resp_r(resp_r),
		.rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
		.result_r(result_r), .result_valid_r(result_valid_r),
		.busy_r(busy_r));
	fpctx_host i_host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_fmt(cmd_fmt), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_ready(rd_ready));
	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic chk_w(input string s, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic chk_x(input string s, input logic [79:0] e, g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic cr(input fpctx_resp_t e);
		chk_w("resp", 32'(e), 32'(resp_r));
	endtask
	// integers normalise so the top mantissa bit is set
	function automatic logic [79:0] l2x(input logic [31:0] a);
		logic [63:0] m;
		logic [14:0] e;
		m = {(a[31] ? -a : a), 32'h0};
		e = INT_EXP;
		if (m == 64'h0) return 80'h0;
		while (!m[63]) begin
			m = m << 1;
			e = e - 15'h0001;
		end
		return {a[31], e, m};
	endfunction
	function automatic logic [79:0] x2d(input logic [31:0] a, b);
		return {a[31], 15'(a[30:20]) - DBL_BIAS + EXT_BIAS, 1'b1,
			a[19:0], b, 11'h000};
	endfunction
	always @(posedge clk) begin
		rv_q <= result_valid_r;
		if (srst) fn = 0;
		else if (rd_valid_r && rd_ready) begin
			fr[fn] = rd_data_r;
			fn++;
		end else if (fn > 0 && resp_r !== RESP_SAVE) begin
			chk_w("frame_word", fw_q.pop_front(), fr[0]);
			chk_w("frame_len", n_q.pop_front(), fn);
			fn = 0;
		end
		if (!srst && result_valid_r && !rv_q)
			chk_x("result", xq.pop_front(), result_r);
	end
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	task automatic save(input logic [31:0] f, input int n);
		fw_q.push_back(f);
		n_q.push_back(n);
		i_host.cmd(CMD_SAVE, FMT_BYTE);
	endtask
	task automatic wait_done;
		int i;
		for (i = 0; i < 3000 && (xq.size() > 0 || fw_q.size() > 0 ||
			busy_r !== 1'b0); i++) @(posedge clk);
		if (i == 3000) begin
			$display("ERROR wait expected idle seen busy");
			err_count++;
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		$display("ERROR watchdog expected end seen timeout");
		err_count++;
		conclude;
	end
	initial begin
		void'($urandom(23893));
		{srst, err_count, comparisons, fn} = {1'b1, 96'h0};
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		save(32'h0, 1);
		wait_done;
		for (int f = 0; f < 7; f++) begin
			v = $urandom;
			w[0] = v;
			w[1] = $urandom;
			w[2] = $urandom;
			case (f)
			0: x = l2x({{24{v[7]}}, v[7:0]});
			1: x = l2x({{16{v[15]}}, v[15:0]});
			2: x = l2x(v);
			3: begin
				w[0][30:23] = 8'h01 + {1'b0, v[29:23]};
				x = {w[0][31], 15'(w[0][30:23]) - SGL_BIAS + EXT_BIAS,
					1'b1, w[0][22:0], 40'h0};
			end
			4: begin
				w[0][30:20] = 11'h001 + {1'b0, v[29:20]};
				x = x2d(w[0], w[1]);
			end
			5: x = {w[0][31:16], w[1], w[2]};
			default: x = 80'h0;
			endcase
			nd = (f == 4) ? 2 : (f >= 5) ? 3 : 1;
			xq.push_back(x);
			i_host.cmd(CMD_INSTR, fpctx_fmt_t'(f));
			cr(RESP_FETCH);
			chk_w("busy", 32'h1, 32'(busy_r));
			for (int k = 0; k < nd; k++) i_host.wr(w[k]);
			wait_done;
		end
		save({FRAME_VERSION, IDLE_SIZE, 16'h0000}, IDLE_WORDS);
		wait_done;
		v = $urandom;
		xq.push_back(l2x(v));
		i_host.cmd(CMD_INSTR, FMT_LONG);
		i_host.wr(v);
		repeat (10) @(posedge clk);
		save({FRAME_VERSION, IDLE_SIZE, 16'h0000}, IDLE_WORDS);
		cr(RESP_WAIT);
		wait_done;
		w[0] = {v[31], 11'h400, v[19:0]};
		w[1] = $urandom;
		i_host.cmd(CMD_INSTR, FMT_DBL);
		i_host.wr(w[0]);
		i_host.cmd(CMD_INSTR, FMT_LONG);
		cr(RESP_WAIT);
		save({FRAME_VERSION, BUSY_SIZE, 16'h0000}, BUSY_WORDS);
		wait_done;
		xq.push_back(x2d(w[0], w[1]));
		i_host.cmd(CMD_RESTORE, FMT_BYTE);
		cr(RESP_RESTORE);
		for (int k = 0; k < BUSY_WORDS; k++) i_host.wr(fr[k]);
		repeat (2) @(posedge clk);
		#1;
		cr(RESP_FETCH);
		i_host.wr(w[1]);
		wait_done;
		i_host.cmd(CMD_RESTORE, FMT_BYTE);
		i_host.wr(32'h0);
		repeat (2) @(posedge clk);
		#1;
		chk_w("result_valid", 32'h0, 32'(result_valid_r));
		cr(RESP_NONE);
		save(32'h0, 1);
		wait_done;
		i_host.cmd(CMD_RESTORE, FMT_BYTE);
		i_host.wr(32'h12340000);
		repeat (2) @(posedge clk);
		#1;
		cr(RESP_FRAME_ERR);
		conclude;
	end
endmodule
`default_nettype wire
